// ==== src/ivsd_pkg.sv ====
// Shared constants and carriers for the input value status and diagnostics
package ivsd_pkg;
    localparam int CHANNELS       = 16;
    localparam int GROUP_SIZE     = 4;
    localparam int GROUPS         = CHANNELS / GROUP_SIZE;
    localparam int IMAGE_BYTES    = 4;
    localparam int STATUS_OFS     = 2;
    localparam int REC0_BYTES     = 4;
    localparam int SPEC_OFS       = 4;
    localparam int SPEC_BYTES     = 8;
    localparam int REC1_BYTES     = SPEC_OFS + SPEC_BYTES;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Generic byte 0 bit positions
    localparam int B0_MOD_FAULT   = 0;
    localparam int B0_INT_FAULT   = 1;
    localparam int B0_EXT_FAULT   = 2;
    localparam int B0_CH_FAULT    = 3;
    localparam int B0_NO_SUPPLY   = 4;
    localparam int B0_NO_PARAM    = 6;
    // Generic byte 2 bit positions
    localparam int B2_NOT_READY   = 2;
    // Per-channel fault fields of the specific part
    localparam int F_WIRE_BREAK   = 0;
    localparam int F_SHORT        = 1;
    localparam int F_FLUTTER      = 2;
    localparam int F_CHANGEOVER   = 3;

    typedef struct packed {
        logic [CHANNELS-1:0] sensor_fail;
        logic [GROUPS-1:0]   supply_fail;
        logic [CHANNELS-1:0] wire_break;
        logic [CHANNELS-1:0] line_short;
        logic [CHANNELS-1:0] flutter;
        logic [CHANNELS-1:0] changeover;
    } ivsd_fault_s;

    typedef struct packed {
        logic [CHANNELS-1:0] status;
        logic [CHANNELS-1:0] value;
    } ivsd_image_s;
endpackage

// ==== src/ivsd_chan_qual.sv ====
// Combinational per-channel fault merge and quality evaluation
module ivsd_chan_qual (
    input  wire logic                 raw_in,
    input  wire logic                 sensor_fail,
    input  wire logic                 supply_fail,
    input  wire logic                 wire_break,
    input  wire logic                 line_short,
    input  wire logic                 flutter,
    input  wire logic                 changeover,
    output logic                      valid,
    output logic [3:0]                fault_bits,
    output logic                      value
);
    logic any_fault;
    always_comb begin
        any_fault = sensor_fail | supply_fail | wire_break | line_short |
                    flutter | changeover;
        valid = ~any_fault;
        // Supply loss also reads as a line fault, so all four in a group set
        fault_bits[ivsd_pkg::F_WIRE_BREAK] = wire_break | supply_fail;
        fault_bits[ivsd_pkg::F_SHORT]      = line_short;
        fault_bits[ivsd_pkg::F_FLUTTER]    = flutter;
        fault_bits[ivsd_pkg::F_CHANGEOVER] = changeover | sensor_fail;
        value = raw_in;
    end
endmodule

// ==== src/ivsd_top.sv ====
// Value status image and diagnostic records of a 16-channel input module
// Summary of operation
// - Status word sits two bytes above inputs
// - Status bit one means valid input
// - Value and status captured same cycle
// - Any channel fault marks signal invalid
// - Record zero is four generic bytes
// - Record one adds specific bytes at four
// - Fault bit is one while fault exists
// - Generic bytes shared by all variants
// - Group supply loss flags four channels
// - Image is four bytes, two plus two
module ivsd_top #(
    parameter int CHANNELS = ivsd_pkg::CHANNELS
) (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic [CHANNELS-1:0]           field_in,
    input  wire ivsd_pkg::ivsd_fault_s         fault_in,
    input  wire logic                          param_missing,
    input  wire logic                          internal_fault,
    input  wire logic                          image_sample,
    input  wire logic [3:0]                    rec_index,
    output logic [7:0]                         input_image_word [4],
    output logic [7:0]                         rec0_byte,
    output logic [7:0]                         rec1_byte,
    output logic [CHANNELS-1:0]                quality_code_link,
    output logic                               group_fault
);
    if (CHANNELS != ivsd_pkg::CHANNELS) begin : g_bad_channels
        $error("Only the documented channel count is supported");
    end

    // Field pins pass two flops; faults come from same-clock logic
    logic [CHANNELS-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic [CHANNELS-1:0] ch_valid, ch_value;
    logic [3:0]          ch_fault [CHANNELS];

    always_comb begin
        sync1_d = field_in;
        sync2_d = sync1_q;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        ivsd_chan_qual u_q (
            .raw_in      (sync2_q[c]),
            .sensor_fail (fault_in.sensor_fail[c]),
            .supply_fail (fault_in.supply_fail[c/ivsd_pkg::GROUP_SIZE]),
            .wire_break  (fault_in.wire_break[c]),
            .line_short  (fault_in.line_short[c]),
            .flutter     (fault_in.flutter[c]),
            .changeover  (fault_in.changeover[c]),
            .valid       (ch_valid[c]),
            .fault_bits  (ch_fault[c]),
            .value       (ch_value[c])
        );
    end

    // Image register: value and status share one load
    ivsd_pkg::ivsd_image_s img_q, img_d;
    always_comb begin
        img_d = img_q;
        if (image_sample) begin
            img_d.value  = ch_value;
            img_d.status = ch_valid;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            img_q <= '0;
        else
            img_q <= img_d;
    end

    // Diagnostic bytes, refreshed every cycle so bits follow the fault
    logic [7:0] gen_q [ivsd_pkg::REC0_BYTES];
    logic [7:0] gen_d [ivsd_pkg::REC0_BYTES];
    logic [7:0] spec_q [ivsd_pkg::SPEC_BYTES];
    logic [7:0] spec_d [ivsd_pkg::SPEC_BYTES];
    logic       any_ch, any_sup;

    always_comb begin
        any_ch  = |(~ch_valid);
        any_sup = |fault_in.supply_fail;
        // One generic layout, independent of module variant
        for (int b = 0; b < ivsd_pkg::REC0_BYTES; b++)
            gen_d[b] = ivsd_pkg::BYTE_RST;
        gen_d[0][ivsd_pkg::B0_MOD_FAULT] = any_ch | internal_fault |
                                           param_missing;
        gen_d[0][ivsd_pkg::B0_INT_FAULT] = internal_fault;
        gen_d[0][ivsd_pkg::B0_EXT_FAULT] = any_ch;
        gen_d[0][ivsd_pkg::B0_CH_FAULT]  = any_ch;
        gen_d[0][ivsd_pkg::B0_NO_SUPPLY] = any_sup;
        gen_d[0][ivsd_pkg::B0_NO_PARAM]  = param_missing;
        gen_d[2][ivsd_pkg::B2_NOT_READY] = param_missing;
        // Two channels of four fault bits per specific byte
        for (int b = 0; b < ivsd_pkg::SPEC_BYTES; b++)
            spec_d[b] = {ch_fault[2*b+1], ch_fault[2*b]};
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int b = 0; b < ivsd_pkg::REC0_BYTES; b++)
                gen_q[b] <= ivsd_pkg::BYTE_RST;
            for (int b = 0; b < ivsd_pkg::SPEC_BYTES; b++)
                spec_q[b] <= ivsd_pkg::BYTE_RST;
        end else begin
            gen_q  <= gen_d;
            spec_q <= spec_d;
        end
    end

    // Record read ports
    logic [7:0] r0_q, r0_d, r1_q, r1_d;
    always_comb begin
        if (rec_index < 4'(ivsd_pkg::REC0_BYTES))
            r0_d = gen_q[rec_index[1:0]];
        else
            r0_d = ivsd_pkg::BYTE_RST;
        if (rec_index < 4'(ivsd_pkg::SPEC_OFS))
            r1_d = gen_q[rec_index[1:0]];
        else if (rec_index < 4'(ivsd_pkg::REC1_BYTES))
            r1_d = spec_q[3'(rec_index - 4'(ivsd_pkg::SPEC_OFS))];
        else
            r1_d = ivsd_pkg::BYTE_RST;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r0_q <= ivsd_pkg::BYTE_RST;
            r1_q <= ivsd_pkg::BYTE_RST;
        end else begin
            r0_q <= r0_d;
            r1_q <= r1_d;
        end
    end

    // Image bytes: values in 0..1, status at +2
    always_comb begin
        input_image_word[0] = img_q.value[7:0];
        input_image_word[1] = img_q.value[15:8];
        input_image_word[ivsd_pkg::STATUS_OFS]   = img_q.status[7:0];
        input_image_word[ivsd_pkg::STATUS_OFS+1] = img_q.status[15:8];
    end
    assign quality_code_link = img_q.status;
    assign rec0_byte   = r0_q;
    assign rec1_byte   = r1_q;
    assign group_fault = gen_q[0][ivsd_pkg::B0_MOD_FAULT];

    property p_status_tracks;
        @(posedge core_clk) disable iff (sys_rst)
        image_sample |=> img_q.status == $past(ch_valid);
    endproperty
    a_status_tracks: assert property (p_status_tracks)
        else $error("Status not loaded with value");

    property p_value_tracks;
        @(posedge core_clk) disable iff (sys_rst)
        image_sample |=> img_q.value == $past(ch_value);
    endproperty
    a_value_tracks: assert property (p_value_tracks)
        else $error("Value not loaded");

    property p_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !image_sample |=> $stable(img_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Image changed without sample");

    property p_invalid;
        @(posedge core_clk) disable iff (sys_rst)
        (image_sample && (|fault_in.flutter)) |=> !(&quality_code_link);
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("Faulted channel reported valid");

    // True when every group with a lost supply reads all invalid
    function automatic logic groups_cleared(
        input logic [ivsd_pkg::CHANNELS-1:0] q,
        input logic [ivsd_pkg::GROUPS-1:0]   s
    );
        groups_cleared = 1'b1;
        for (int g = 0; g < ivsd_pkg::GROUPS; g++)
            if (s[g] &&
                q[g*ivsd_pkg::GROUP_SIZE +: ivsd_pkg::GROUP_SIZE] != '0)
                groups_cleared = 1'b0;
    endfunction

    property p_group;
        @(posedge core_clk) disable iff (sys_rst)
        image_sample |=>
            groups_cleared(quality_code_link, $past(fault_in.supply_fail));
    endproperty
    a_group: assert property (p_group)
        else $error("Supply loss missed a group channel");

    property p_fault_bit;
        @(posedge core_clk) disable iff (sys_rst)
        internal_fault |=> gen_q[0][ivsd_pkg::B0_INT_FAULT];
    endproperty
    a_fault_bit: assert property (p_fault_bit)
        else $error("Fault bit not set");

    property p_clear_bit;
        @(posedge core_clk) disable iff (sys_rst)
        (!param_missing && !internal_fault && (&ch_valid)) |=>
            gen_q[0] == 8'h00;
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("Fault bit set without fault");

    property p_rec_share;
        @(posedge core_clk) disable iff (sys_rst)
        (rec_index < 4'h4) ##1 $stable(gen_q[0]) |-> r0_q == r1_q;
    endproperty
    a_rec_share: assert property (p_rec_share)
        else $error("Record one generic bytes differ");

    property p_rec0_len;
        @(posedge core_clk) disable iff (sys_rst)
        (rec_index >= 4'h4) |=> r0_q == 8'h00;
    endproperty
    a_rec0_len: assert property (p_rec0_len)
        else $error("Record zero longer than four bytes");
endmodule

// ==== tb/ivsd_ctl_model.sv ====
// Backplane controller model that samples the image and reads records
module ivsd_ctl_model (
    input  wire logic       core_clk,
    output logic            image_sample,
    output logic [3:0]      rec_index,
    input  wire logic [7:0] rec0_byte,
    input  wire logic [7:0] rec1_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        image_sample = 1'b0;
        rec_index    = 4'h0;
    end

    // One high cycle loads values and status in the same update
    task automatic take_image;
        @(negedge core_clk);
        image_sample = 1'b1;
        @(negedge core_clk);
        image_sample = 1'b0;
    endtask

    // Index held, bytes taken one edge later
    task automatic read_rec(input logic [3:0] idx,
                            output logic [7:0] r0,
                            output logic [7:0] r1);
        @(negedge core_clk);
        rec_index = idx;
        @(negedge core_clk);
        r0 = rec0_byte;
        r1 = rec1_byte;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the input value status and diagnostics block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  core_clk;
    logic                  sys_rst;
    logic [15:0]           field_in;
    ivsd_pkg::ivsd_fault_s fault_in;
    logic                  param_missing;
    logic                  internal_fault;
    logic                  image_sample;
    logic [3:0]            rec_index;
    logic [7:0]            img [4];
    logic [7:0]            rec0_byte;
    logic [7:0]            rec1_byte;
    logic [15:0]           quality_code_link;
    logic                  group_fault;
    int                    err_count;
    int                    tests_run;

    ivsd_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .field_in(field_in), .fault_in(fault_in),
        .param_missing(param_missing), .internal_fault(internal_fault),
        .image_sample(image_sample), .rec_index(rec_index),
        .input_image_word(img), .rec0_byte(rec0_byte),
        .rec1_byte(rec1_byte), .quality_code_link(quality_code_link),
        .group_fault(group_fault));

    ivsd_ctl_model ctl (.core_clk(core_clk), .image_sample(image_sample),
        .rec_index(rec_index), .rec0_byte(rec0_byte),
        .rec1_byte(rec1_byte));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Expected nibble of one channel in the specific record part
    function automatic logic [3:0] nib(input int c);
        nib = {fault_in.changeover[c] | fault_in.sensor_fail[c],
               fault_in.flutter[c], fault_in.line_short[c],
               fault_in.wire_break[c] | fault_in.supply_fail[c/4]};
    endfunction

    task automatic test_image;
        field_in = 16'hA5C3;
        cycles(3);
        chk16(quality_code_link, 16'h0000);
        ctl.take_image();
        chk8(img[0], 8'hC3);
        chk8(img[1], 8'hA5);
        chk8(img[2], 8'hFF);
        chk8(img[3], 8'hFF);
        chk16(quality_code_link, 16'hFFFF);
    endtask

    // One fault kind per channel plus a lost group supply
    task automatic test_faults;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] e1;
        fault_in.sensor_fail[0] = 1'b1;
        fault_in.wire_break[3]  = 1'b1;
        fault_in.line_short[6]  = 1'b1;
        fault_in.flutter[9]     = 1'b1;
        fault_in.changeover[12] = 1'b1;
        fault_in.supply_fail[2] = 1'b1;
        field_in = 16'h0F0F;
        cycles(3);
        chk16(quality_code_link, 16'hFFFF);
        chk8(img[0], 8'hC3);
        ctl.take_image();
        chk8(img[2], 8'hB6);
        chk8(img[3], 8'hE0);
        chk16(quality_code_link, 16'hE0B6);
        chk8(8'(group_fault), 8'h01);
        for (int i = 0; i < 16; i++) begin
            ctl.read_rec(i[3:0], r0, r1);
            e1 = (i >= 4 && i < 12) ? {nib(2*i-7), nib(2*i-8)} : 8'h00;
            if (i < 4) begin
                chk8(r1, r0);
                chk8(r0, (i == 0) ? 8'h1D : 8'h00);
            end else begin
                chk8(r0, 8'h00);
                chk8(r1, e1);
            end
        end
    endtask

    // Generic bytes follow module level faults while they last
    task automatic gen_case(input logic pm, input logic intf,
                            input logic [7:0] e0, input logic [7:0] e2);
        logic [7:0] r0;
        logic [7:0] r1;
        param_missing  = pm;
        internal_fault = intf;
        cycles(3);
        ctl.read_rec(4'h0, r0, r1);
        chk8(r0, e0);
        chk8(8'(group_fault), {7'h00, e0[0]});
        ctl.read_rec(4'h2, r0, r1);
        chk8(r0, e2);
    endtask

    task automatic test_generic;
        fault_in = '0;
        gen_case(1'b0, 1'b1, 8'h03, 8'h00);
        gen_case(1'b1, 1'b0, 8'h41, 8'h04);
        gen_case(1'b0, 1'b0, 8'h00, 8'h00);
        ctl.take_image();
        chk16(quality_code_link, 16'hFFFF);
        chk8(img[0], 8'h0F);
    endtask

    task automatic finish_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Run needs about 70 cycles; cut a hang well beyond that
    initial begin
        #200000;
        err_count++;
        finish_test();
    end

    initial begin
        err_count      = 0;
        tests_run      = 0;
        sys_rst        = 1'b1;
        field_in       = 16'h0000;
        fault_in       = '0;
        param_missing  = 1'b0;
        internal_fault = 1'b0;
        cycles(5);
        sys_rst = 1'b0;
        chk8(img[2], 8'h00);
        chk8(8'(group_fault), 8'h00);
        test_image();
        test_faults();
        test_generic();
        finish_test();
    end
endmodule
